// File: irq_prio_defs.vh
/*
 * Offsets, field positions, reset values and codes for the interrupt
 * priority register block. Assumes inclusion by bare name.
 */
`ifndef IRQ_PRIO_DEFS_VH
`define IRQ_PRIO_DEFS_VH

// ----------------------------------------
// register byte offsets on apb
// ----------------------------------------
`define OFS_DMA4_PMP_PRIORITY     12'h000
`define OFS_SPI_RX_KEY_PRIORITY   12'h004
`define OFS_UART3_PRIORITY        12'h008
`define OFS_LEVEL_STATUS          12'h00C

// ----------------------------------------
// field low bit positions
// ----------------------------------------
`define POS_DMA_CH4               8
`define POS_PARALLEL_PORT         4
`define POS_SERIAL2_RX            12
`define POS_SERIAL1_RX            8
`define POS_KEY_PROGRAM_DONE      0
`define POS_UART_C_TX             12
`define POS_UART_C_RX             8
`define POS_UART_C_ERR            4

// ----------------------------------------
// write masks and reset values
// ----------------------------------------
`define MASK_DMA4_PMP             16'h0770
`define MASK_SPI_RX_KEY           16'h7707
`define MASK_UART3                16'h7770
`define RST_DMA4_PMP              16'h0440
`define RST_SPI_RX_KEY            16'h4404
`define RST_UART3                 16'h4440

// ----------------------------------------
// priority codes
// ----------------------------------------
`define PRIO_DISABLED             3'h0
`define PRIO_MIDDLE               3'h4
`define NUM_SOURCES               8

`endif

// File: prio_arbiter.v
/*
 * Picks the highest priority pending and enabled source.
 * Assumes levels and requests are on the same clock as the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module prio_arbiter #(
  parameter N = 8
) (
  input  wire [N-1:0]   req,
  input  wire [3*N-1:0] levels,
  output reg            active,
  output reg  [2:0]     win_level,
  output reg  [3:0]     win_id
);

  integer i;
  reg [2:0] lv;

  // ----------------------------------------
  // linear level compare, lower index wins ties
  // ----------------------------------------
  always @* begin
    active    = 1'b0;
    win_level = 3'h0;
    win_id    = 4'h0;
    lv        = 3'h0;
    for (i = 0; i < N; i = i + 1) begin
      lv = levels[3*i +: 3];
      // code zero never enters the compare
      if (req[i] && (lv != 3'h0) && (lv > win_level)) begin
        active    = 1'b1;
        win_level = lv;
        win_id    = i[3:0];
      end
    end
  end

endmodule

`default_nettype wire

// File: interrupt_priority_control_regs.v
/*
 * Interrupt priority register block with an apb slave and arbitration.
 * Assumes source requests come from logic on ref_clk.
 */
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defs.vh"

// What this block does
// - three-bit field; code 111 gives level seven, the highest
// - code 001 gives level one, lowest enabled level
// - code 000 disables the source; its request never wins
// - unused bits read zero and ignore writes
// - dma channel four priority in bits 10:8
// - parallel port priority in bits 6:4 of the same register
// - serial1 receive priority in bits 10:8
// - uart c transmit priority in bits 14:12
// - uart c receive in bits 10:8, error in bits 6:4
module interrupt_priority_control_regs (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [7:0]  src_req,
  output reg         cpu_irq_q,
  output reg  [2:0]  cpu_level_q,
  output reg  [3:0]  cpu_src_id_q,
  output wire [23:0] src_levels
);

  reg  [15:0] dma4_pmp_q;
  reg  [15:0] spi_rx_key_q;
  reg  [15:0] uart3_q;
  wire        wr_en;
  wire        hit;
  wire [15:0] wdata16;
  wire [15:0] strb_mask;
  wire        arb_active;
  wire [2:0]  arb_level;
  wire [3:0]  arb_id;

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire [2:0] dma_ch4_prio          = dma4_pmp_q[`POS_DMA_CH4 +: 3];
  wire [2:0] parallel_port_prio    = dma4_pmp_q[`POS_PARALLEL_PORT +: 3];
  wire [2:0] serial1_rx_prio       = spi_rx_key_q[`POS_SERIAL1_RX +: 3];
  wire [2:0] serial2_rx_prio       = spi_rx_key_q[`POS_SERIAL2_RX +: 3];
  wire [2:0] key_program_done_prio = spi_rx_key_q[`POS_KEY_PROGRAM_DONE +: 3];
  wire [2:0] uart_c_tx_prio        = uart3_q[`POS_UART_C_TX +: 3];
  wire [2:0] uart_c_rx_prio        = uart3_q[`POS_UART_C_RX +: 3];
  wire [2:0] uart_c_err_prio       = uart3_q[`POS_UART_C_ERR +: 3];

  // source order: 0 dma4, 1 pmp, 2 spi1rx, 3 spi2rx, 4 key,
  // 5 uart tx, 6 uart rx, 7 uart err
  assign src_levels = {uart_c_err_prio, uart_c_rx_prio, uart_c_tx_prio,
                       key_program_done_prio, serial2_rx_prio,
                       serial1_rx_prio, parallel_port_prio,
                       dma_ch4_prio};

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  assign pready    = 1'b1;
  assign hit       = (paddr == `OFS_DMA4_PMP_PRIORITY) ||
                     (paddr == `OFS_SPI_RX_KEY_PRIORITY) ||
                     (paddr == `OFS_UART3_PRIORITY) ||
                     (paddr == `OFS_LEVEL_STATUS);
  // unmapped addresses answer with an error, reads give zero
  assign pslverr   = psel & penable & ~hit;
  assign wr_en     = psel & penable & pwrite;
  assign wdata16   = pwdata[15:0];
  assign strb_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [15:0] bmask;
    input [15:0] fmask;
    reg   [15:0] m;
    begin
      m     = bmask & fmask;
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      dma4_pmp_q   <= `RST_DMA4_PMP;
      spi_rx_key_q <= `RST_SPI_RX_KEY;
      uart3_q      <= `RST_UART3;
    end else if (wr_en) begin
      if (paddr == `OFS_DMA4_PMP_PRIORITY) begin
        dma4_pmp_q <= merge(dma4_pmp_q, wdata16, strb_mask,
                            `MASK_DMA4_PMP);
      end
      if (paddr == `OFS_SPI_RX_KEY_PRIORITY) begin
        spi_rx_key_q <= merge(spi_rx_key_q, wdata16, strb_mask,
                              `MASK_SPI_RX_KEY);
      end
      if (paddr == `OFS_UART3_PRIORITY) begin
        uart3_q <= merge(uart3_q, wdata16, strb_mask, `MASK_UART3);
      end
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        `OFS_DMA4_PMP_PRIORITY:   prdata = {16'h0000, dma4_pmp_q};
        `OFS_SPI_RX_KEY_PRIORITY: prdata = {16'h0000, spi_rx_key_q};
        `OFS_UART3_PRIORITY:      prdata = {16'h0000, uart3_q};
        `OFS_LEVEL_STATUS:        prdata = {24'h00_0000, cpu_irq_q,
                                            cpu_src_id_q, cpu_level_q};
        default:                  prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // arbitration toward the core
  // ----------------------------------------
  prio_arbiter #(
    .N(`NUM_SOURCES)
  ) u_arb (
    .req       (src_req),
    .levels    (src_levels),
    .active    (arb_active),
    .win_level (arb_level),
    .win_id    (arb_id)
  );

  // registered so the core sees a clean level, one cycle late
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cpu_irq_q    <= 1'b0;
      cpu_level_q  <= 3'h0;
      cpu_src_id_q <= 4'h0;
    end else begin
      cpu_irq_q    <= arb_active;
      cpu_level_q  <= arb_level;
      cpu_src_id_q <= arb_id;
    end
  end

endmodule

`default_nettype wire

// File: irq_prio_chk_asserts.sv
/* concurrent checks on the priority block ports.
   assumes one clock, ref_clk, and sync active-low rst_n. */
`timescale 1ns/1ps
`default_nettype none
module irq_prio_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  src_req,
  input wire logic        cpu_irq_q,
  input wire logic [2:0]  cpu_level_q,
  input wire logic [3:0]  cpu_src_id_q,
  input wire logic [23:0] src_levels
);
  // ------------------------------------
  // reset, read data and winner outputs against live field levels
  // ------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic rd_now = psel && !pwrite;
  rst_val_a:
    assert property (disable iff (1'h0) !rst_n |=>
      src_levels == 24'h924924 && !cpu_irq_q) else $error("reset value");
  dma_pmp_a:
    assert property (rd_now && paddr == 12'h000 |-> prdata == {21'h0,
      src_levels[2:0], 1'h0, src_levels[5:3], 4'h0}) else $error("reg 0");
  spi_key_a:
    assert property (rd_now && paddr == 12'h004 |-> prdata == {17'h0,
      src_levels[11:9], 1'h0, src_levels[8:6], 5'h0, src_levels[14:12]})
      else $error("reg 4");
  uart_c_a:
    assert property (rd_now && paddr == 12'h008 |-> prdata == {17'h0,
      src_levels[17:15], 1'h0, src_levels[20:18], 1'h0, src_levels[23:21],
      4'h0}) else $error("reg 8");
  off_src_a:
    assert property (src_req == 8'h01 && src_levels[2:0] == 3'h0 |=>
      !cpu_irq_q) else $error("disabled source won");
  lone_src_a:
    assert property (src_req == 8'h01 && src_levels[2:0] != 3'h0 |=>
      cpu_irq_q && cpu_src_id_q == 4'h0 &&
      cpu_level_q == $past(src_levels[2:0])) else $error("lone source");
  higher_a:
    assert property (src_req == 8'h03 && src_levels[5:3] > src_levels[2:0]
      |=> cpu_src_id_q == 4'h1 && cpu_level_q == $past(src_levels[5:3]))
      else $error("lower level won");
  top_code_a:
    assert property (src_req == 8'hFF && src_levels[5:3] == 3'h7 |=>
      cpu_level_q == 3'h7) else $error("all ones not top");
endmodule
bind interrupt_priority_control_regs irq_prio_chk i_chk (.ref_clk, .rst_n,
  .psel, .pwrite, .paddr, .prdata, .src_req, .cpu_irq_q, .cpu_level_q,
  .cpu_src_id_q, .src_levels);
`default_nettype wire

// File: req_sources.sv
/* peripheral request sources at the far side.
   assumes requests are levels launched on ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module req_sources (
  input  wire logic       ref_clk,
  input  wire logic [7:0] want,
  output var  logic [7:0] src_req
);
  // registered so requests never change near the sampling edge
  initial src_req = 8'h00;
  always @(posedge ref_clk) begin
    src_req <= want;
  end
endmodule
`default_nettype wire

// File: tb_top.sv
/* self-checking bench for the priority register block.
   assumes apb with zero wait states and registered winner outputs. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, pready, pslverr, cpu_irq_q, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  want = 8'h0, src_req;
  logic [2:0]  cpu_level_q;
  logic [3:0]  cpu_src_id_q;
  logic [23:0] src_levels;
  int          n_errors = 0, comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  interrupt_priority_control_regs i_dut (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr,
    .src_req, .cpu_irq_q, .cpu_level_q, .cpu_src_id_q, .src_levels);
  req_sources i_src (.ref_clk, .want, .src_req);
  // ------------------------------------
  // shared tasks
  // ------------------------------------
  task automatic chk(input string s, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      n_errors++;
      wrap_up();
    end
  endtask
  // winner is {irq, level, id}; two edges of latency plus settling
  task automatic req(input logic [7:0] w, input logic [7:0] exp);
    @(posedge ref_clk);
    want <= w;
    repeat (3) @(posedge ref_clk);
    chk("winner", {cpu_irq_q, cpu_level_q, cpu_src_id_q}, exp);
  endtask
  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_regs;
    logic [31:0] rv [3] = '{32'h0440, 32'h4404, 32'h4440};
    logic [31:0] mk [3] = '{32'h0770, 32'h7707, 32'h7770};
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, 12'(4 * i), 32'h0);
      chk("reset", rd, rv[i]);
      apb(1'h1, 12'(4 * i), 32'hFFFFFFFF);
      apb(1'h0, 12'(4 * i), 32'h0);
      chk("ones", rd, mk[i]);
      apb(1'h1, 12'(4 * i), 32'h0);
      apb(1'h0, 12'(4 * i), 32'hFFFFFFFF);
      chk("zeros", rd, 32'h0);
    end
  endtask
  task automatic t_fields;
    apb(1'h1, 12'h000, 32'h0120);
    apb(1'h1, 12'h004, 32'h6305);
    apb(1'h1, 12'h008, 32'h7530);
    // last write lands at the edge apb returned on; let it settle
    @(negedge ref_clk);
    chk("dma pmp", src_levels[5:0], 32'h11);
    chk("spi1", src_levels[8:6], 32'h3);
    chk("uart tx", src_levels[17:15], 32'h7);
    chk("uart rx err", src_levels[23:18], 32'h1D);
  endtask
  task automatic t_arb;
    req(8'h01, 8'h90);
    req(8'h03, 8'hA1);
    apb(1'h1, 12'h000, 32'h0070);
    req(8'h01, 8'h00);
    req(8'hFF, 8'hF1);
    apb(1'h0, 12'h00C, 32'h0);
    chk("status", rd, 32'h8F);
  endtask
  task automatic t_unmapped;
    apb(1'h1, 12'h010, 32'hFFFFFFFF);
    chk("slverr", err, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk("kept", rd, 32'h0070);
    chk("no slverr", err, 32'h0);
  endtask
  task automatic t_reset;
    @(posedge ref_clk);
    want <= 8'h00;
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk("rst again", rd, 32'h0440);
    apb(1'h0, 12'h00C, 32'h0);
    chk("rst status", rd, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_regs();
    t_fields();
    t_arb();
    t_unmapped();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
